// ### hw/attr_bank_cfg.svh
/*
  constants for the attribute bank: identifiers, widths, resets, ranges.
  assumes inclusion by bare name from package and modules.
*/
`ifndef ATTR_BANK_CFG_SVH
`define ATTR_BANK_CFG_SVH

`define ID_WIDTH                 16
`define VAL_WIDTH                20
`define VENDOR_ID_BASE           16'h8000

`define ID_SWITCH_SEARCH_TIME    16'h0010
`define ID_PROMOTION_PDU_MAX     16'h0011
`define ID_PROMOTION_PDU_PERIOD  16'h0012
`define ID_BEACON_SLOTS          16'h0013
`define ID_CONTENTION_TX_ATT     16'h0014
`define ID_CONTROL_RETX_TIMER    16'h0015
`define ID_CONTENTION_BACKOFF    16'h0016
`define ID_CHANNEL_SENSE_COUNT   16'h0017
`define ID_CONTROL_RETX_LIMIT    16'h0018
`define ID_MAC_AVG_SMOOTHING     16'h0019
`define ID_TX_QUEUE_DEPTH        16'h00b0
`define ID_RX_QUEUE_DEPTH        16'h00b1
`define ID_TX_LATENCY_US         16'h00b2
`define ID_RX_LATENCY_US         16'h00b3
`define ID_GAIN_MINIMUM          16'h00b4
`define ID_GAIN_STEP_SIZE        16'h00b5
`define ID_GAIN_STEP_COUNT       16'h00b6

`define RST_SWITCH_SEARCH_TIME   8'h18
`define RST_PROMOTION_PDU_MAX    8'h02
`define RST_PROMOTION_PDU_PERIOD 8'h05
`define RST_BEACON_SLOTS         8'h05
`define RST_CONTENTION_TX_ATT    8'h05
`define RST_CONTROL_RETX_TIMER   8'h0f
`define RST_CONTROL_RETX_LIMIT   8'h03
`define RST_MAC_AVG_SMOOTHING    8'h03

`define MIN_SWITCH_SEARCH_TIME   8'h10
`define MAX_SWITCH_SEARCH_TIME   8'h20
`define MIN_PROMOTION_PDU_MAX    8'h01
`define MAX_PROMOTION_PDU_MAX    8'h04
`define MIN_PROMOTION_PDU_PERIOD 8'h02
`define MAX_PROMOTION_PDU_PERIOD 8'h08
`define MIN_BEACON_SLOTS         8'h01
`define MAX_BEACON_SLOTS         8'h05
`define MIN_CONTENTION_TX_ATT    8'h02
`define MAX_CONTENTION_TX_ATT    8'h05
`define MIN_CONTROL_RETX_TIMER   8'h02
`define MAX_CONTROL_RETX_TIMER   8'h14
`define MIN_CONTROL_RETX_LIMIT   8'h03
`define MAX_CONTROL_RETX_LIMIT   8'h05
`define MIN_MAC_AVG_SMOOTHING    8'h00
`define MAX_MAC_AVG_SMOOTHING    8'h07

`define MIN_BACKOFF_SYMBOLS      4'h1
`define MAX_BACKOFF_SYMBOLS      4'hf
`define SENSE_COUNT_VALUE        8'h03

`define LFSR_SEED                16'hace1
`define LFSR_TAPS                16'hb400

`endif

// ### hw/attr_bank_pkg.sv
/*
  types for the attribute bank.
  assumes attr_bank_cfg.svh on the include path.
*/
package attr_bank_pkg;
  `include "attr_bank_cfg.svh"

  typedef enum logic [1:0] {
    st_idle_type   = 2'b00,
    st_decode_type = 2'b01,
    st_answer_type = 2'b11
  } access_state_type;

  typedef enum logic [1:0] {
    res_ok_type        = 2'b00,
    res_read_only_type = 2'b01,
    res_unknown_type   = 2'b10,
    res_range_type     = 2'b11
  } result_type;

  typedef struct packed {
    logic [7:0] switch_search_time;
    logic [7:0] promotion_pdu_max;
    logic [7:0] promotion_pdu_period;
    logic [7:0] beacon_slots_per_frame;
    logic [7:0] contention_tx_attempts;
    logic [7:0] control_retx_timer;
    logic [7:0] control_retx_limit;
    logic [7:0] mac_average_smoothing;
  } mac_vars_type;

  typedef struct packed {
    logic [15:0] lfsr;
    logic [3:0]  backoff;
  } backoff_state_type;
endpackage

// ### hw/backoff_source.sv
/*
  random backoff source for the shared contention period: a 16-bit lfsr
  folded into 1..15 symbols, refreshed on request.
  assumes i_next is a one-cycle pulse from same-clock logic.
*/
`timescale 1ns/1ps
`include "attr_bank_cfg.svh"

module backoff_source (
  // clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  // control
  input  wire logic       i_next,
  // result
  output logic [3:0]      o_backoff
);
  attr_bank_pkg::backoff_state_type state_ff;
  attr_bank_pkg::backoff_state_type nxt_state;
  logic [15:0]                      stepped;

  always_comb begin
    nxt_state = state_ff;
    stepped   = state_ff.lfsr[0] ? ((state_ff.lfsr >> 1) ^ `LFSR_TAPS)
                                 : (state_ff.lfsr >> 1);
    nxt_state.lfsr = stepped;
    // zero is folded away so the wait stays within 1..15 symbols
    if (i_next) begin
      nxt_state.backoff = (stepped[3:0] == 4'h0) ? `MIN_BACKOFF_SYMBOLS
                                                : stepped[3:0];
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_ff.lfsr    <= `LFSR_SEED;
      state_ff.backoff <= `MAX_BACKOFF_SYMBOLS;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_backoff = state_ff.backoff;
endmodule // backoff_source

// ### hw/plc_mac_phy_attribute_bank.sv
/*
  management attribute store: constant phy implementation parameters and
  mac variable attributes reached by 16-bit identifier via get/set.
  assumes requests are one-cycle pulses from same-clock logic.
*/
`timescale 1ns/1ps
`include "attr_bank_cfg.svh"

module plc_mac_phy_attribute_bank #(
  parameter logic [9:0]  TX_QUEUE_DEPTH  = 10'h004,
  parameter logic [9:0]  RX_QUEUE_DEPTH  = 10'h004,
  parameter logic [19:0] TX_LATENCY_US   = 20'h003e8,
  parameter logic [19:0] RX_LATENCY_US   = 20'h003e8,
  parameter logic [7:0]  GAIN_MINIMUM    = 8'h00,
  parameter logic [2:0]  GAIN_STEP_SIZE  = 3'h6,
  parameter logic [7:0]  GAIN_STEP_COUNT = 8'h05
) (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // management request
  input  wire logic        i_mac_mgmt_get,
  input  wire logic        i_mac_mgmt_set,
  input  wire logic        i_phy_mgmt_get,
  input  wire logic [15:0] i_attr_id,
  input  wire logic [19:0] i_attr_wdata,
  // backoff refresh
  input  wire logic        i_backoff_next,
  // management answer
  output logic             o_done,
  output logic [1:0]       o_result,
  output logic [19:0]      o_attr_rdata,
  output logic             o_busy,
  // live settings for the mac engine
  output logic [7:0]       o_switch_search_time,
  output logic [7:0]       o_promotion_pdu_max,
  output logic [7:0]       o_promotion_pdu_period,
  output logic [7:0]       o_beacon_slots_per_frame,
  output logic [7:0]       o_contention_tx_attempts,
  output logic [7:0]       o_control_retx_timer,
  output logic [7:0]       o_control_retx_limit,
  output logic [2:0]       o_mac_average_smoothing,
  output logic [3:0]       o_contention_random_backoff,
  output logic [7:0]       o_channel_sense_count
);

  typedef struct packed {
    attr_bank_pkg::access_state_type state;
    attr_bank_pkg::mac_vars_type     vars;
    logic                            is_set;
    logic                            is_phy;
    logic [15:0]                     id;
    logic [19:0]                     wdata;
    logic                            done;
    logic [1:0]                      result;
    logic [19:0]                     rdata;
    logic [3:0]                      backoff;
    logic                            busy;
    logic [7:0]                      sense;
  } bank_state_type;

  bank_state_type state_ff;
  bank_state_type nxt_state;
  logic [3:0]     backoff_now;
  logic [19:0]    read_val;
  logic           known;
  logic           writable;
  logic           in_range;
  logic [7:0]     w8;

  backoff_source u_backoff (
    .i_clock   (i_clock),
    .i_rst_n   (i_rst_n),
    .i_next    (i_backoff_next),
    .o_backoff (backoff_now)
  );

  // read mux; phy values come straight from parameters so writes cannot reach them
  always_comb begin
    read_val = 20'h00000;
    known    = 1'b1;
    writable = 1'b0;
    if (state_ff.is_phy) begin
      case (state_ff.id)
        `ID_TX_QUEUE_DEPTH:  read_val = {10'h000, TX_QUEUE_DEPTH};
        `ID_RX_QUEUE_DEPTH:  read_val = {10'h000, RX_QUEUE_DEPTH};
        `ID_TX_LATENCY_US:   read_val = TX_LATENCY_US;
        `ID_RX_LATENCY_US:   read_val = RX_LATENCY_US;
        `ID_GAIN_MINIMUM:    read_val = {12'h000, GAIN_MINIMUM};
        `ID_GAIN_STEP_SIZE:  read_val = {17'h00000, GAIN_STEP_SIZE};
        `ID_GAIN_STEP_COUNT: read_val = {12'h000, GAIN_STEP_COUNT};
        default:             known    = 1'b0;
      endcase
    end else begin
      writable = 1'b1;
      case (state_ff.id)
        `ID_SWITCH_SEARCH_TIME:   read_val = {12'h000, state_ff.vars.switch_search_time};
        `ID_PROMOTION_PDU_MAX:    read_val = {12'h000, state_ff.vars.promotion_pdu_max};
        `ID_PROMOTION_PDU_PERIOD: read_val = {12'h000, state_ff.vars.promotion_pdu_period};
        `ID_BEACON_SLOTS:         read_val = {12'h000, state_ff.vars.beacon_slots_per_frame};
        `ID_CONTENTION_TX_ATT:    read_val = {12'h000, state_ff.vars.contention_tx_attempts};
        `ID_CONTROL_RETX_TIMER:   read_val = {12'h000, state_ff.vars.control_retx_timer};
        `ID_CONTROL_RETX_LIMIT:   read_val = {12'h000, state_ff.vars.control_retx_limit};
        `ID_MAC_AVG_SMOOTHING:    read_val = {12'h000, state_ff.vars.mac_average_smoothing};
        `ID_CONTENTION_BACKOFF: begin
          read_val = {16'h0000, state_ff.backoff};
          writable = 1'b0;
        end
        `ID_CHANNEL_SENSE_COUNT: begin
          read_val = {12'h000, `SENSE_COUNT_VALUE};
          writable = 1'b0;
        end
        default: begin
          // vendor and unassigned standard identifiers are both unknown here
          known    = 1'b0;
          writable = 1'b0;
        end
      endcase
    end
  end

  // range check of the written value against the documented span
  always_comb begin
    w8       = state_ff.wdata[7:0];
    in_range = (state_ff.wdata[19:8] == 12'h000);
    case (state_ff.id)
      `ID_SWITCH_SEARCH_TIME:
        in_range = in_range && (w8 >= `MIN_SWITCH_SEARCH_TIME)
                            && (w8 <= `MAX_SWITCH_SEARCH_TIME);
      `ID_PROMOTION_PDU_MAX:
        in_range = in_range && (w8 >= `MIN_PROMOTION_PDU_MAX)
                            && (w8 <= `MAX_PROMOTION_PDU_MAX);
      `ID_PROMOTION_PDU_PERIOD:
        in_range = in_range && (w8 >= `MIN_PROMOTION_PDU_PERIOD)
                            && (w8 <= `MAX_PROMOTION_PDU_PERIOD);
      `ID_BEACON_SLOTS:
        in_range = in_range && (w8 >= `MIN_BEACON_SLOTS)
                            && (w8 <= `MAX_BEACON_SLOTS);
      `ID_CONTENTION_TX_ATT:
        in_range = in_range && (w8 >= `MIN_CONTENTION_TX_ATT)
                            && (w8 <= `MAX_CONTENTION_TX_ATT);
      `ID_CONTROL_RETX_TIMER:
        in_range = in_range && (w8 >= `MIN_CONTROL_RETX_TIMER)
                            && (w8 <= `MAX_CONTROL_RETX_TIMER);
      `ID_CONTROL_RETX_LIMIT:
        in_range = in_range && (w8 >= `MIN_CONTROL_RETX_LIMIT)
                            && (w8 <= `MAX_CONTROL_RETX_LIMIT);
      `ID_MAC_AVG_SMOOTHING:
        in_range = in_range && (w8 <= `MAX_MAC_AVG_SMOOTHING);
      default:
        in_range = 1'b0;
    endcase
  end

  always_comb begin
    nxt_state         = state_ff;
    nxt_state.done    = 1'b0;
    nxt_state.backoff = backoff_now;
    case (state_ff.state)
      attr_bank_pkg::st_idle_type: begin
        // one request at a time; a second pulse while busy is dropped
        if (i_mac_mgmt_get || i_mac_mgmt_set || i_phy_mgmt_get) begin
          nxt_state.state  = attr_bank_pkg::st_decode_type;
          // busy is its own flop so the port carries no state decode
          nxt_state.busy   = 1'b1;
          nxt_state.is_set = i_mac_mgmt_set && !i_phy_mgmt_get;
          nxt_state.is_phy = i_phy_mgmt_get;
          nxt_state.id     = i_attr_id;
          nxt_state.wdata  = i_attr_wdata;
        end
      end
      attr_bank_pkg::st_decode_type: begin
        nxt_state.state  = attr_bank_pkg::st_answer_type;
        nxt_state.done   = 1'b1;
        nxt_state.rdata  = 20'h00000;
        nxt_state.result = attr_bank_pkg::res_ok_type;
        if (!known) begin
          nxt_state.result = attr_bank_pkg::res_unknown_type;
        end else if (!state_ff.is_set) begin
          nxt_state.rdata  = read_val;
        end else if (!writable) begin
          nxt_state.result = attr_bank_pkg::res_read_only_type;
        end else if (!in_range) begin
          nxt_state.result = attr_bank_pkg::res_range_type;
        end else begin
          // accepted writes land at once and steer the live outputs
          case (state_ff.id)
            `ID_SWITCH_SEARCH_TIME:   nxt_state.vars.switch_search_time     = w8;
            `ID_PROMOTION_PDU_MAX:    nxt_state.vars.promotion_pdu_max      = w8;
            `ID_PROMOTION_PDU_PERIOD: nxt_state.vars.promotion_pdu_period   = w8;
            `ID_BEACON_SLOTS:         nxt_state.vars.beacon_slots_per_frame = w8;
            `ID_CONTENTION_TX_ATT:    nxt_state.vars.contention_tx_attempts = w8;
            `ID_CONTROL_RETX_TIMER:   nxt_state.vars.control_retx_timer     = w8;
            `ID_CONTROL_RETX_LIMIT:   nxt_state.vars.control_retx_limit     = w8;
            `ID_MAC_AVG_SMOOTHING:    nxt_state.vars.mac_average_smoothing  = w8;
            default:                  nxt_state.result = attr_bank_pkg::res_unknown_type;
          endcase
        end
      end
      attr_bank_pkg::st_answer_type: begin
        nxt_state.state = attr_bank_pkg::st_idle_type;
        nxt_state.busy  = 1'b0;
      end
      default: begin
        nxt_state.state = attr_bank_pkg::st_idle_type;
        nxt_state.busy  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_ff.state  <= attr_bank_pkg::st_idle_type;
      state_ff.vars.switch_search_time     <= `RST_SWITCH_SEARCH_TIME;
      state_ff.vars.promotion_pdu_max      <= `RST_PROMOTION_PDU_MAX;
      state_ff.vars.promotion_pdu_period   <= `RST_PROMOTION_PDU_PERIOD;
      state_ff.vars.beacon_slots_per_frame <= `RST_BEACON_SLOTS;
      state_ff.vars.contention_tx_attempts <= `RST_CONTENTION_TX_ATT;
      state_ff.vars.control_retx_timer     <= `RST_CONTROL_RETX_TIMER;
      state_ff.vars.control_retx_limit     <= `RST_CONTROL_RETX_LIMIT;
      state_ff.vars.mac_average_smoothing  <= `RST_MAC_AVG_SMOOTHING;
      state_ff.is_set  <= 1'b0;
      state_ff.is_phy  <= 1'b0;
      state_ff.id      <= 16'h0000;
      state_ff.wdata   <= 20'h00000;
      state_ff.done    <= 1'b0;
      state_ff.result  <= 2'h0;
      state_ff.rdata   <= 20'h00000;
      state_ff.backoff <= `MAX_BACKOFF_SYMBOLS;
      state_ff.busy    <= 1'b0;
      state_ff.sense   <= `SENSE_COUNT_VALUE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_done                      = state_ff.done;
  assign o_result                    = state_ff.result;
  assign o_attr_rdata                = state_ff.rdata;
  assign o_busy                      = state_ff.busy;
  assign o_switch_search_time        = state_ff.vars.switch_search_time;
  assign o_promotion_pdu_max         = state_ff.vars.promotion_pdu_max;
  assign o_promotion_pdu_period      = state_ff.vars.promotion_pdu_period;
  assign o_beacon_slots_per_frame    = state_ff.vars.beacon_slots_per_frame;
  assign o_contention_tx_attempts    = state_ff.vars.contention_tx_attempts;
  assign o_control_retx_timer        = state_ff.vars.control_retx_timer;
  assign o_control_retx_limit        = state_ff.vars.control_retx_limit;
  assign o_mac_average_smoothing     = state_ff.vars.mac_average_smoothing[2:0];
  assign o_contention_random_backoff = state_ff.backoff;
  assign o_channel_sense_count       = state_ff.sense;
endmodule // plc_mac_phy_attribute_bank

// ### testbench/attr_bank_properties.sv
/*
  port checks for the attribute bank, bound to its top module.
  assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module attr_bank_properties (
  // clock and reset
  input wire logic        i_clock,
  input wire logic        i_rst_n,
  // request
  input wire logic        i_mac_mgmt_get,
  input wire logic        i_mac_mgmt_set,
  input wire logic        i_phy_mgmt_get,
  input wire logic [15:0] i_attr_id,
  // answer and live outputs
  input wire logic        o_done,
  input wire logic [1:0]  o_result,
  input wire logic [19:0] o_attr_rdata,
  input wire logic        o_busy,
  input wire logic [3:0]  o_contention_random_backoff,
  input wire logic [7:0]  o_channel_sense_count
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  logic take;
  logic set_take;
  assign take = (i_mac_mgmt_get | i_mac_mgmt_set | i_phy_mgmt_get) & ~o_busy;
  assign set_take = i_mac_mgmt_set & ~i_phy_mgmt_get & ~o_busy;
  property p_done_lat; take |-> ##2 o_done; endproperty
  a_done_lat: assert property (p_done_lat) else $error("late answer");
  property p_done_cause; o_done |-> $past(take, 2); endproperty
  a_done_cause: assert property (p_done_cause) else $error("answer without take");
  // busy must cover the whole flight, else a second request slips in
  property p_busy; take |=> o_busy [*2] ##1 !o_busy; endproperty
  a_busy: assert property (p_busy) else $error("busy window wrong");
  property p_ro; set_take && i_attr_id inside {16'h0016, 16'h0017} |-> ##2 o_result == 2'h1;
  endproperty
  a_ro: assert property (p_ro) else $error("read-only set not refused");
  property p_vendor; set_take && i_attr_id[15] |-> ##2 o_result == 2'h2; endproperty
  a_vendor: assert property (p_vendor) else $error("vendor id not refused");
  property p_phy_set; set_take && i_attr_id[15:4] == 12'h00b |-> ##2 o_result == 2'h2;
  endproperty
  a_phy_set: assert property (p_phy_set) else $error("phy id set not refused");
  property p_set_rdata; set_take |-> ##2 o_attr_rdata == 20'h00000; endproperty
  a_set_rdata: assert property (p_set_rdata) else $error("set returned data");
  property p_result_hold; $changed(o_result) && $past(i_rst_n) |-> o_done; endproperty
  a_result_hold: assert property (p_result_hold) else $error("result moved");
  property p_backoff; o_contention_random_backoff != 4'h0; endproperty
  a_backoff: assert property (p_backoff) else $error("backoff zero");
  property p_sense; o_channel_sense_count inside {[8'h02:8'h05]}; endproperty
  a_sense: assert property (p_sense) else $error("sense count out of range");
endmodule // attr_bank_properties

bind plc_mac_phy_attribute_bank attr_bank_properties u_props (
  .i_clock, .i_rst_n, .i_mac_mgmt_get, .i_mac_mgmt_set, .i_phy_mgmt_get, .i_attr_id,
  .o_done, .o_result, .o_attr_rdata, .o_busy, .o_contention_random_backoff,
  .o_channel_sense_count
);

// ### testbench/mgmt_requester.sv
/*
  management-side model: issues one get or set and collects the answer.
  assumes the bank answers within eight cycles of taking a request.
*/
`timescale 1ns/1ps
module mgmt_requester (
  // clock
  input  wire logic        i_clock,
  // request
  output logic             o_mac_mgmt_get,
  output logic             o_mac_mgmt_set,
  output logic             o_phy_mgmt_get,
  output logic [15:0]      o_attr_id,
  output logic [19:0]      o_attr_wdata,
  // answer
  input  wire logic        i_done,
  input  wire logic [1:0]  i_result,
  input  wire logic [19:0] i_attr_rdata
);
  initial {o_mac_mgmt_get, o_mac_mgmt_set, o_phy_mgmt_get, o_attr_id, o_attr_wdata} = '0;
  // op 0 mac get, 1 mac set, 2 phy get; one attribute per request
  task automatic access(input logic [1:0] op, input logic [15:0] id, input logic [19:0] wd,
                        output logic [1:0] res, output logic [19:0] rd, output bit ok);
    ok = 1'b0;
    res = 2'h0;
    rd = 20'h0;
    @(negedge i_clock);
    o_attr_id = id; // full 16-bit identifier
    o_attr_wdata = wd;
    {o_phy_mgmt_get, o_mac_mgmt_set, o_mac_mgmt_get} = 3'b001 << op;
    @(negedge i_clock);
    {o_phy_mgmt_get, o_mac_mgmt_set, o_mac_mgmt_get} = 3'b000;
    // released lines flip so a late sample cannot pass by luck
    o_attr_id = ~id;
    o_attr_wdata = ~wd;
    for (int n = 0; n < 8 && !ok; n++) begin
      if (i_done === 1'b1) begin
        ok = 1'b1;
        res = i_result;
        rd = i_attr_rdata;
      end else begin
        @(negedge i_clock);
      end
    end
    // one more cycle so busy has dropped before the next take
    @(negedge i_clock);
  endtask
endmodule // mgmt_requester

// ### testbench/plc_mac_phy_attribute_bank_tb.sv
/*
  self-checking bench for the attribute bank, one task per scenario.
  assumes the bank under hw/ and mgmt_requester beside this file.
*/
`timescale 1ns/1ps
module plc_mac_phy_attribute_bank_tb;
  localparam logic [7:0] RW_ID [8] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h18, 8'h19};
  localparam logic [7:0] RW_DEF [8] = '{8'h18, 8'h02, 8'h05, 8'h05, 8'h05, 8'h0f, 8'h03, 8'h03};
  localparam logic [7:0] RW_MIN [8] = '{8'h10, 8'h01, 8'h02, 8'h01, 8'h02, 8'h02, 8'h03, 8'h00};
  localparam logic [7:0] RW_MAX [8] = '{8'h20, 8'h04, 8'h08, 8'h05, 8'h05, 8'h14, 8'h05, 8'h07};
  localparam logic [19:0] PHY_EXP [7] = '{20'h003ff, 20'h00004, 20'hfffff, 20'h00001,
                                          20'h000f6, 20'h00006, 20'h00007};
  logic        i_clock;
  logic        i_rst_n;
  logic        i_backoff_next;
  logic        mac_get, mac_set, phy_get, done, busy;
  logic [15:0] attr_id;
  logic [19:0] wdata, rdata;
  logic [1:0]  result;
  logic [3:0]  backoff;
  logic [7:0]  sense;
  // live settings, one byte per writable attribute in RW_ID order
  wire  [63:0] live;
  int          miscompares;
  int          n_tests;

  plc_mac_phy_attribute_bank #(
    .TX_QUEUE_DEPTH(10'h3ff), .TX_LATENCY_US(20'hfffff),
    .RX_LATENCY_US(20'h00001), .GAIN_MINIMUM(8'hf6), .GAIN_STEP_COUNT(8'h07)
  ) dut (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_mac_mgmt_get(mac_get), .i_mac_mgmt_set(mac_set),
    .i_phy_mgmt_get(phy_get), .i_attr_id(attr_id), .i_attr_wdata(wdata),
    .i_backoff_next(i_backoff_next), .o_done(done), .o_result(result), .o_attr_rdata(rdata),
    .o_busy(busy), .o_switch_search_time(live[7:0]), .o_promotion_pdu_max(live[15:8]),
    .o_promotion_pdu_period(live[23:16]), .o_beacon_slots_per_frame(live[31:24]),
    .o_contention_tx_attempts(live[39:32]), .o_control_retx_timer(live[47:40]),
    .o_control_retx_limit(live[55:48]), .o_mac_average_smoothing(live[58:56]),
    .o_contention_random_backoff(backoff), .o_channel_sense_count(sense)
  );

  assign live[63:59] = 5'h00;

  mgmt_requester u_mgr (
    .i_clock(i_clock), .o_mac_mgmt_get(mac_get), .o_mac_mgmt_set(mac_set),
    .o_phy_mgmt_get(phy_get), .o_attr_id(attr_id), .o_attr_wdata(wdata),
    .i_done(done), .i_result(result), .i_attr_rdata(rdata)
  );

  task automatic chk_val(input logic [19:0] got, input logic [19:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_res(input logic [1:0] got, input logic [1:0] exp);
    chk_val({18'h0, got}, {18'h0, exp});
  endtask

  task automatic close_out();
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // one request through the model; a missing answer ends the run
  task automatic req(input logic [1:0] op, input logic [15:0] id, input logic [19:0] wd,
                     input logic [1:0] er, output logic [19:0] rd);
    logic [1:0] res;
    bit         ok;
    u_mgr.access(op, id, wd, res, rd, ok);
    if (!ok) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      close_out();
    end else begin
      chk_res(res, er);
    end
  endtask

  task automatic t_defaults();
    logic [19:0] rd;
    chk_val({18'h0, done, busy}, 20'h0);
    for (int i = 0; i < 8; i++) begin
      req(2'h0, {8'h00, RW_ID[i]}, 20'h0, 2'h0, rd);
      chk_val(rd, {12'h0, RW_DEF[i]});
      chk_val({12'h0, live[8*i +: 8]}, {12'h0, RW_DEF[i]});
    end
  endtask

  task automatic t_phy();
    logic [19:0] rd [7];
    int          g, c, s;
    for (int i = 0; i < 7; i++) begin
      req(2'h2, 16'h00b0 + 16'(i), 20'h0, 2'h0, rd[i]);
      chk_val(rd[i], PHY_EXP[i]);
    end
    g = int'($signed(rd[4][7:0]));
    c = int'(rd[6][7:0]);
    s = int'(rd[5][2:0]);
    chk_val({19'h0, g <= 0}, 20'h1);
    chk_val({19'h0, s <= 6}, 20'h1);
    chk_val({19'h0, g + (c - 1) * s >= 21}, 20'h1);
    req(2'h1, 16'h00b6, 20'h1, 2'h2, rd[0]);
    req(2'h2, 16'h00b6, 20'h0, 2'h0, rd[0]);
    chk_val(rd[0], PHY_EXP[6]);
  endtask

  // both range ends accepted, one past the high end, one below any nonzero low end and stray high bits refused
  task automatic t_ranges();
    logic [19:0] rd;
    logic [15:0] id;
    logic [7:0]  lo, hi;
    for (int i = 0; i < 8; i++) begin
      id = {8'h00, RW_ID[i]};
      lo = RW_MIN[i];
      hi = RW_MAX[i];
      req(2'h1, id, {12'h0, hi}, 2'h0, rd);
      req(2'h1, id, {12'h0, 8'(hi + 8'h01)}, 2'h3, rd);
      if (lo != 8'h00) req(2'h1, id, {12'h0, 8'(lo - 8'h01)}, 2'h3, rd);
      req(2'h1, id, {12'h1, lo}, 2'h3, rd);
      req(2'h0, id, 20'h0, 2'h0, rd);
      chk_val(rd, {12'h0, hi});
      chk_val({12'h0, live[8*i +: 8]}, {12'h0, hi});
      req(2'h1, id, {12'h0, lo}, 2'h0, rd);
    end
  endtask

  task automatic t_refusals();
    logic [19:0] rd;
    req(2'h0, 16'h0016, 20'h0, 2'h0, rd);
    chk_val({19'h0, rd >= 20'h1 && rd <= 20'hf}, 20'h1);
    req(2'h1, 16'h0016, 20'h5, 2'h1, rd);
    req(2'h0, 16'h0017, 20'h0, 2'h0, rd);
    chk_val({19'h0, rd >= 20'h2 && rd <= 20'h5}, 20'h1);
    chk_val({12'h0, sense}, rd);
    req(2'h1, 16'h0017, 20'h2, 2'h1, rd);
    req(2'h1, 16'h8010, 20'h11, 2'h2, rd);
    req(2'h1, 16'hffff, 20'h1, 2'h2, rd);
    req(2'h1, 16'h1010, 20'h11, 2'h2, rd);
    req(2'h1, 16'h001a, 20'h1, 2'h2, rd);
    req(2'h0, 16'h0010, 20'h0, 2'h0, rd);
    chk_val(rd, 20'h00010);
  endtask

  task automatic t_backoff();
    logic [3:0] first;
    bit         moved;
    first = backoff;
    moved = 1'b0;
    for (int i = 0; i < 20; i++) begin
      i_backoff_next = 1'b1;
      @(negedge i_clock);
      i_backoff_next = 1'b0;
      repeat (2) @(negedge i_clock);
      chk_val({19'h0, backoff != 4'h0}, 20'h1);
      if (backoff !== first) moved = 1'b1;
    end
    chk_val({19'h0, moved}, 20'h1);
  endtask

  task automatic t_mid_reset();
    logic [19:0] rd;
    req(2'h1, 16'h0015, 20'h2, 2'h0, rd);
    i_rst_n = 1'b0;
    repeat (2) @(negedge i_clock);
    i_rst_n = 1'b1;
    t_defaults();
  endtask

  always #50 i_clock = ~i_clock;

  initial begin
    i_clock = 1'b0;
    i_rst_n = 1'b0;
    i_backoff_next = 1'b0;
    miscompares = 0;
    n_tests = 0;
    repeat (10) @(negedge i_clock);
    i_rst_n = 1'b1;
    t_defaults();
    t_phy();
    t_ranges();
    t_refusals();
    t_backoff();
    t_mid_reset();
    close_out();
  end
endmodule // plc_mac_phy_attribute_bank_tb
